// File: shared/bsf_params.svh
// Register offsets, field positions and reset values of the bit and flag unit
`ifndef BSF_PARAMS_SVH
`define BSF_PARAMS_SVH
// ==========================================
// Register word indices (address bits 4:2)
`define BSF_CMD_OFS      3'd0
`define BSF_STATUS_OFS   3'd1
`define BSF_REG_SEL_OFS  3'd2
`define BSF_REG_DATA_OFS 3'd3
`define BSF_IO_SEL_OFS   3'd4
`define BSF_IO_DATA_OFS  3'd5
`define BSF_SP_OFS       3'd6
`define BSF_NUM_REGS     7
// ==========================================
// Command fields
`define BSF_OP_LSB       0
`define BSF_DST_LSB      8
`define BSF_SRC_LSB      16
`define BSF_BIT_LSB      24
// ==========================================
// Status register bits
`define BSF_FLAG_C       0
`define BSF_FLAG_Z       1
`define BSF_FLAG_N       2
`define BSF_FLAG_V       3
`define BSF_FLAG_T       6
`define BSF_FLAG_I       7
`define BSF_BUSY_BIT     8
// ==========================================
// Reset values and responses
`define BSF_FLAGS_RST    8'h00
`define BSF_CMD_RST      32'h0000_0000
`define BSF_RESP_OKAY    2'h0
`define BSF_RESP_SLVERR  2'h2
`endif

// File: shared/bsf_pkg.sv
// Types of the bit and flag unit
`default_nettype none
package bsf_pkg;
  typedef enum logic [4:0] {
    push_op,
    pop_op,
    io_bit_set_op,
    io_bit_clear_op,
    logical_left_shift_op,
    logical_right_shift_op,
    rotate_left_carry_op,
    rotate_right_carry_op,
    arith_right_shift_op,
    nibble_swap_op,
    status_bit_set_op,
    status_bit_clear_op,
    bit_to_transfer_flag_op,
    transfer_flag_to_bit_op,
    carry_set_op,
    carry_clear_op,
    negative_set_op,
    negative_clear_op,
    zero_flag_set_op,
    zero_flag_clear_op,
    irq_enable_op,
    irq_disable_op
  } bsf_op_t;
  typedef enum logic [0:0] {
    bsf_idle,
    bsf_second
  } bsf_state_t;
endpackage
`default_nettype wire

// File: src/bsf_unit.sv
// Bit, shift and flag execution unit with AXI4-Lite register access
// ==========================================
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "bsf_params.svh"
module bsf_unit #(
  parameter int STACK_DEPTH = 16
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  localparam int SPW = $clog2(STACK_DEPTH);

  // ==========================================
  // Helpers
  function automatic logic [3:0] reg_dec(input logic [31:0] a);
    if (a[31:5] != 27'h0 || a[1:0] != 2'h0 || a[4:2] >= 3'(`BSF_NUM_REGS))
    begin
      reg_dec = 4'h8;
    end
    else
    begin
      reg_dec = {1'b0, a[4:2]};
    end
  endfunction

  function automatic logic two_cycle(input bsf_pkg::bsf_op_t o);
    two_cycle = (o == bsf_pkg::push_op) || (o == bsf_pkg::pop_op) ||
                (o == bsf_pkg::io_bit_set_op) || (o == bsf_pkg::io_bit_clear_op);
  endfunction

  function automatic logic [7:0] shift_flags(input logic [7:0] s, input logic [7:0] r, input logic c);
    logic [7:0] f;
    f = s;
    f[`BSF_FLAG_Z] = (r == 8'h00);
    f[`BSF_FLAG_C] = c;
    f[`BSF_FLAG_N] = r[7];
    f[`BSF_FLAG_V] = r[7] ^ c;
    shift_flags = f;
  endfunction

  // ==========================================
  // State
  logic [31:0]           awaddr_q;
  logic                  aw_have_q;
  logic [31:0]           wdata_q;
  logic [3:0]            wstrb_q;
  logic                  w_have_q;
  logic [31:0]           cmd_q;
  logic                  start_q;
  bsf_pkg::bsf_state_t   state_q;
  logic [7:0]            flags_q;
  logic [4:0]            reg_sel_q;
  logic [4:0]            io_sel_q;
  logic [SPW-1:0]        sp_q;
  logic [7:0]            regs_q [32];
  logic [7:0]            io_q [32];
  logic [7:0]            stack_q [STACK_DEPTH];

  bsf_pkg::bsf_op_t      op;
  logic [4:0]            dst;
  logic [4:0]            src;
  logic [2:0]            bsel;
  logic                  busy;
  logic                  commit;
  logic                  wr_go;
  logic [3:0]            wr_idx;
  logic                  wr_err;
  logic [7:0]            rd;
  logic [7:0]            s_val;
  logic [7:0]            res_d;
  logic                  reg_we_d;
  logic [7:0]            flags_d;
  logic [7:0]            io_d;
  logic                  io_we_d;
  logic [31:0]           rd_mux;

  assign op     = bsf_pkg::bsf_op_t'(cmd_q[`BSF_OP_LSB +: 5]);
  assign dst    = cmd_q[`BSF_DST_LSB +: 5];
  assign src    = cmd_q[`BSF_SRC_LSB +: 5];
  assign bsel   = cmd_q[`BSF_BIT_LSB +: 3];
  assign busy   = start_q || (state_q != bsf_pkg::bsf_idle);
  assign commit = (start_q && !two_cycle(op)) || (state_q == bsf_pkg::bsf_second);
  assign wr_go  = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_idx = reg_dec(awaddr_q);
  assign wr_err = wr_idx[3] || (wr_idx[2:0] == `BSF_CMD_OFS && busy);
  assign rd     = regs_q[dst];
  assign s_val  = regs_q[src];

  // ==========================================
  // Write channels
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q     <= 1'b0;
      awaddr_q      <= 32'h0;
      s_axi_awready <= 1'b0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_q     <= 1'b1;
      awaddr_q      <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end
    else
    begin
      if (wr_go)
      begin
        aw_have_q <= 1'b0;
      end
      s_axi_awready <= !aw_have_q && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_have_q     <= 1'b0;
      wdata_q      <= 32'h0;
      wstrb_q      <= 4'h0;
      s_axi_wready <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_q     <= 1'b1;
      wdata_q      <= s_axi_wdata;
      wstrb_q      <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      if (wr_go)
      begin
        w_have_q <= 1'b0;
      end
      s_axi_wready <= !w_have_q && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `BSF_RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_err ? `BSF_RESP_SLVERR : `BSF_RESP_OKAY;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================
  // Command and sequencing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmd_q   <= `BSF_CMD_RST;
      start_q <= 1'b0;
    end
    else
    begin
      start_q <= 1'b0;
      if (wr_go && !wr_err && wr_idx[2:0] == `BSF_CMD_OFS)
      begin
        for (int i = 0; i < 4; i++)
        begin
          if (wstrb_q[i])
          begin
            cmd_q[i*8 +: 8] <= wdata_q[i*8 +: 8];
          end
        end
        start_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= bsf_pkg::bsf_idle;
    end
    else
    begin
      unique case (state_q)
        bsf_pkg::bsf_idle:
        begin
          if (start_q && two_cycle(op))
          begin
            state_q <= bsf_pkg::bsf_second;
          end
        end
        bsf_pkg::bsf_second:
        begin
          state_q <= bsf_pkg::bsf_idle;
        end
      endcase
    end
  end

  // ==========================================
  // Datapath
  always_comb
  begin
    res_d    = rd;
    reg_we_d = 1'b0;
    flags_d  = flags_q;
    io_d     = io_q[dst];
    io_we_d  = 1'b0;
    unique case (op)
      bsf_pkg::pop_op:
      begin
        res_d    = stack_q[sp_q - SPW'(1)];
        reg_we_d = 1'b1;
      end
      bsf_pkg::io_bit_set_op:
      begin
        io_d[bsel] = 1'b1;
        io_we_d    = 1'b1;
      end
      bsf_pkg::io_bit_clear_op:
      begin
        io_d[bsel] = 1'b0;
        io_we_d    = 1'b1;
      end
      bsf_pkg::logical_left_shift_op:
      begin
        res_d    = {rd[6:0], 1'b0};
        reg_we_d = 1'b1;
        flags_d  = shift_flags(flags_q, res_d, rd[7]);
      end
      bsf_pkg::logical_right_shift_op:
      begin
        res_d    = {1'b0, rd[7:1]};
        reg_we_d = 1'b1;
        flags_d  = shift_flags(flags_q, res_d, rd[0]);
      end
      bsf_pkg::rotate_left_carry_op:
      begin
        res_d    = {rd[6:0], flags_q[`BSF_FLAG_C]};
        reg_we_d = 1'b1;
        flags_d  = shift_flags(flags_q, res_d, rd[7]);
      end
      bsf_pkg::rotate_right_carry_op:
      begin
        res_d    = {flags_q[`BSF_FLAG_C], rd[7:1]};
        reg_we_d = 1'b1;
        flags_d  = shift_flags(flags_q, res_d, rd[0]);
      end
      bsf_pkg::arith_right_shift_op:
      begin
        res_d    = {rd[7], rd[7:1]};
        reg_we_d = 1'b1;
        flags_d  = shift_flags(flags_q, res_d, rd[0]);
      end
      bsf_pkg::nibble_swap_op:
      begin
        res_d    = {rd[3:0], rd[7:4]};
        reg_we_d = 1'b1;
      end
      bsf_pkg::status_bit_set_op:   flags_d[bsel] = 1'b1;
      bsf_pkg::status_bit_clear_op: flags_d[bsel] = 1'b0;
      bsf_pkg::bit_to_transfer_flag_op: flags_d[`BSF_FLAG_T] = s_val[bsel];
      bsf_pkg::transfer_flag_to_bit_op:
      begin
        res_d[bsel] = flags_q[`BSF_FLAG_T];
        reg_we_d    = 1'b1;
      end
      bsf_pkg::carry_set_op:      flags_d[`BSF_FLAG_C] = 1'b1;
      bsf_pkg::carry_clear_op:    flags_d[`BSF_FLAG_C] = 1'b0;
      bsf_pkg::negative_set_op:   flags_d[`BSF_FLAG_N] = 1'b1;
      bsf_pkg::negative_clear_op: flags_d[`BSF_FLAG_N] = 1'b0;
      bsf_pkg::zero_flag_set_op:  flags_d[`BSF_FLAG_Z] = 1'b1;
      bsf_pkg::zero_flag_clear_op: flags_d[`BSF_FLAG_Z] = 1'b0;
      bsf_pkg::irq_enable_op:     flags_d[`BSF_FLAG_I] = 1'b1;
      bsf_pkg::irq_disable_op:    flags_d[`BSF_FLAG_I] = 1'b0;
      default:
      begin
        res_d = rd;
      end
    endcase
  end

  // ==========================================
  // Storage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flags_q <= `BSF_FLAGS_RST;
    end
    else if (commit)
    begin
      flags_q <= flags_d;
    end
    else if (wr_go && !wr_err && wr_idx[2:0] == `BSF_STATUS_OFS && wstrb_q[0])
    begin
      flags_q <= wdata_q[7:0];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < 32; i++)
      begin
        regs_q[i] <= 8'h00;
      end
    end
    else if (commit && reg_we_d)
    begin
      regs_q[dst] <= res_d;
    end
    else if (wr_go && !wr_err && wr_idx[2:0] == `BSF_REG_DATA_OFS && wstrb_q[0])
    begin
      regs_q[reg_sel_q] <= wdata_q[7:0];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < 32; i++)
      begin
        io_q[i] <= 8'h00;
      end
    end
    else if (commit && io_we_d)
    begin
      io_q[dst] <= io_d;
    end
    else if (wr_go && !wr_err && wr_idx[2:0] == `BSF_IO_DATA_OFS && wstrb_q[0])
    begin
      io_q[io_sel_q] <= wdata_q[7:0];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (commit && op == bsf_pkg::push_op)
    begin
      stack_q[sp_q] <= s_val;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sp_q <= '0;
    end
    else if (commit && op == bsf_pkg::push_op)
    begin
      sp_q <= sp_q + SPW'(1);
    end
    else if (commit && op == bsf_pkg::pop_op)
    begin
      sp_q <= sp_q - SPW'(1);
    end
    else if (wr_go && !wr_err && wr_idx[2:0] == `BSF_SP_OFS && wstrb_q[0])
    begin
      sp_q <= wdata_q[SPW-1:0];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      reg_sel_q <= 5'h00;
      io_sel_q  <= 5'h00;
    end
    else if (wr_go && !wr_err && wstrb_q[0])
    begin
      if (wr_idx[2:0] == `BSF_REG_SEL_OFS)
      begin
        reg_sel_q <= wdata_q[4:0];
      end
      if (wr_idx[2:0] == `BSF_IO_SEL_OFS)
      begin
        io_sel_q <= wdata_q[4:0];
      end
    end
  end

  // ==========================================
  // Read channel
  always_comb
  begin
    rd_mux = 32'h0;
    unique case (reg_dec(s_axi_araddr))
      4'h0: rd_mux = cmd_q;
      4'h1: rd_mux = {23'h0, busy, flags_q};
      4'h2: rd_mux = {27'h0, reg_sel_q};
      4'h3: rd_mux = {24'h0, regs_q[reg_sel_q]};
      4'h4: rd_mux = {27'h0, io_sel_q};
      4'h5: rd_mux = {24'h0, io_q[io_sel_q]};
      4'h6: rd_mux = {{(32-SPW){1'b0}}, sp_q};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `BSF_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= reg_dec(s_axi_araddr) == 4'h8 ? `BSF_RESP_SLVERR : `BSF_RESP_OKAY;
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
    else
    begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: testbench/bsf_unit_props.sv
// Bus timing checks of the bit and flag unit
`timescale 1ns/10ps
`default_nettype none
module bsf_unit_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  // ==========================================
  // Helpers
  logic bad_aw;
  logic bad_ar;
  assign bad_aw = (s_axi_awaddr[1:0] != 2'h0) || (s_axi_awaddr >= 32'h1c);
  assign bad_ar = (s_axi_araddr[1:0] != 2'h0) || (s_axi_araddr >= 32'h1c);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence wr_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // ==========================================
  // Assertions
  chk_wr_answer_time: assert property (wr_both_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  chk_rd_answer_time: assert property (rd_taken |-> ##[1:2] s_axi_rvalid)
    else $error("read response late");
  chk_rd_data_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
    && $stable(s_axi_rresp))
    else $error("read data not held");
  chk_wr_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  chk_aw_ready_drop: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address ready stayed high");
  chk_ar_ready_back: assert property (s_axi_rvalid && s_axi_rready |-> ##[1:3] s_axi_arready)
    else $error("read address ready not restored");
  chk_wr_unmapped_err: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && bad_aw
    |-> ##[1:2] (s_axi_bvalid && s_axi_bresp == 2'h2))
    else $error("unmapped write not refused");
  chk_rd_unmapped_err: assert property (rd_taken ##0 bad_ar
    |-> ##[1:2] (s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0))
    else $error("unmapped read not refused");
endmodule
`default_nettype wire

// File: testbench/tb_bsf_unit.sv
// Self-checking testbench of the bit and flag unit
`timescale 1ns/10ps
`default_nettype none
module tb_bsf_unit;
  typedef struct {bsf_pkg::bsf_op_t op; logic [7:0] d, s; logic [2:0] b; logic [7:0] er, es;} bsf_row_t;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  int          n_mismatch, comparisons;
  bsf_row_t    rows [19] = '{
    '{bsf_pkg::logical_left_shift_op, 8'h81, 8'h30, 3'h0, 8'h02, 8'h39},
    '{bsf_pkg::logical_right_shift_op, 8'h81, 8'h00, 3'h0, 8'h40, 8'h09},
    '{bsf_pkg::rotate_left_carry_op, 8'h80, 8'h01, 3'h0, 8'h01, 8'h09},
    '{bsf_pkg::rotate_right_carry_op, 8'h01, 8'h00, 3'h0, 8'h00, 8'h0b},
    '{bsf_pkg::rotate_right_carry_op, 8'h02, 8'h01, 3'h0, 8'h81, 8'h0c},
    '{bsf_pkg::arith_right_shift_op, 8'h85, 8'h00, 3'h0, 8'hc2, 8'h05},
    '{bsf_pkg::nibble_swap_op, 8'ha5, 8'h3f, 3'h0, 8'h5a, 8'h3f},
    '{bsf_pkg::status_bit_set_op, 8'h11, 8'h00, 3'h6, 8'h11, 8'h40},
    '{bsf_pkg::status_bit_clear_op, 8'h11, 8'hff, 3'h7, 8'h11, 8'h7f},
    '{bsf_pkg::bit_to_transfer_flag_op, 8'h04, 8'h00, 3'h2, 8'h04, 8'h40},
    '{bsf_pkg::transfer_flag_to_bit_op, 8'h00, 8'h40, 3'h7, 8'h80, 8'h40},
    '{bsf_pkg::carry_set_op, 8'h5a, 8'h00, 3'h0, 8'h5a, 8'h01},
    '{bsf_pkg::carry_clear_op, 8'h5a, 8'hff, 3'h0, 8'h5a, 8'hfe},
    '{bsf_pkg::negative_set_op, 8'h5a, 8'h00, 3'h0, 8'h5a, 8'h04},
    '{bsf_pkg::negative_clear_op, 8'h5a, 8'hff, 3'h0, 8'h5a, 8'hfb},
    '{bsf_pkg::zero_flag_set_op, 8'h5a, 8'h00, 3'h0, 8'h5a, 8'h02},
    '{bsf_pkg::zero_flag_clear_op, 8'h5a, 8'hff, 3'h0, 8'h5a, 8'hfd},
    '{bsf_pkg::irq_enable_op, 8'h5a, 8'h00, 3'h0, 8'h5a, 8'h80},
    '{bsf_pkg::irq_disable_op, 8'h5a, 8'hff, 3'h0, 8'h5a, 8'h7f}};
  bsf_unit uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  // ==========================================
  // Checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    if (n_mismatch == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic hang;
    n_mismatch++;
    $display("Error at %0t: no answer", $time);
    summarize();
  endtask
  // ==========================================
  // Bus cycles
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
        break;
    end
    if (n == 40)
      hang();
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
        break;
    end
    if (n == 40)
      hang();
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic run_op(input bsf_pkg::bsf_op_t op, input logic [4:0] dst, input logic [2:0] b);
    int n;
    wr(32'h00, {5'h0, b, 3'h0, dst, 3'h0, dst, 3'h0, op}, rs);
    for (n = 0; n < 20; n++)
    begin
      rd(32'h04, rv, rs);
      if (rv[8] === 1'b0)
        break;
    end
    if (n == 20)
      hang();
  endtask
  // ==========================================
  // Stimulus
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} <= '0;
    s_axi_wstrb <= 4'hf;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(32'h04, rv, rs);
    chk(rv, 32'h0);
    wr(32'h08, 32'h3, rs);
    foreach (rows[i])
    begin
      wr(32'h0c, {24'h0, rows[i].d}, rs);
      wr(32'h04, {24'h0, rows[i].s}, rs);
      chk({30'h0, rs}, 32'h0);
      run_op(rows[i].op, 5'h3, rows[i].b);
      rd(32'h0c, rv, rs);
      chk(rv, {24'h0, rows[i].er});
      rd(32'h04, rv, rs);
      chk(rv, {24'h0, rows[i].es});
      chk({30'h0, rs}, 32'h0);
    end
    wr(32'h0c, 32'h3c, rs);
    run_op(bsf_pkg::push_op, 5'h3, 3'h0);
    rd(32'h18, rv, rs);
    chk(rv, 32'h1);
    wr(32'h0c, 32'h0, rs);
    run_op(bsf_pkg::pop_op, 5'h3, 3'h0);
    rd(32'h0c, rv, rs);
    chk(rv, 32'h3c);
    rd(32'h18, rv, rs);
    chk(rv, 32'h0);
    wr(32'h10, 32'h4, rs);
    wr(32'h14, 32'h55, rs);
    run_op(bsf_pkg::io_bit_set_op, 5'h4, 3'h1);
    rd(32'h14, rv, rs);
    chk(rv, 32'h57);
    run_op(bsf_pkg::io_bit_clear_op, 5'h4, 3'h0);
    rd(32'h14, rv, rs);
    chk(rv, 32'h56);
    rd(32'h04, rv, rs);
    chk(rv, 32'h7f);
    s_axi_wstrb <= 4'he;
    wr(32'h04, 32'h00, rs);
    s_axi_wstrb <= 4'hf;
    run_op(bsf_pkg::bsf_op_t'(5'h16), 5'h3, 3'h0);
    rd(32'h0c, rv, rs);
    chk(rv, 32'h3c);
    rd(32'h04, rv, rs);
    chk(rv, 32'h7f);
    wr(32'h1c, 32'hff, rs);
    chk({30'h0, rs}, 32'h2);
    rd(32'h1c, rv, rs);
    chk({rv[29:0], rs}, 32'h2);
    wr(32'h04, 32'hff, rs);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(32'h04, rv, rs);
    chk(rv, 32'h0);
    rd(32'h08, rv, rs);
    chk(rv, 32'h0);
    wr(32'h08, 32'h3, rs);
    rd(32'h0c, rv, rs);
    chk(rv, 32'h0);
    summarize();
  end
endmodule
bind bsf_unit bsf_unit_props u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire
